// *** src/asir_regs.v ***
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "asir_defines.vh"
module asir_regs (
	// clock and reset
	input  wire        clk,
	input  wire        srst,
	// axi4-lite write address
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [3:0]  s_axi_awaddr,
	// axi4-lite write data
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	// axi4-lite read address
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	input  wire [3:0]  s_axi_araddr,
	// axi4-lite read data
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	// acquisition events from the same clock domain
	input  wire        vwin_active,
	input  wire        frame_start,
	input  wire        frame_end,
	input  wire [5:0]  src_events,
	input  wire        overstep,
	// connector pins
	input  wire        aux_board_pin,
	input  wire [4:0]  gp_input_pins,
	input  wire [1:0]  switch_pins,
	// outputs
	output reg  [6:0]  gp_output_pins,
	output reg  [1:0]  acq_state_now,
	output reg         irq
);

	// ====================
	// registers
	reg  [1:0]  acq_command_next;
	reg         in_vertical_window;
	reg  [2:0]  frame_start_tally;
	reg  [5:0]  src_enable;
	reg         frame_end_irq_gate;
	reg         global_irq_enable;
	reg         aux_camera_reserved;
	reg         irq_pending_summary;
	reg         overstep_sticky;
	reg  [6:0]  irq_status;
	reg  [6:0]  irq_mask;
	reg  [7:0]  pin_meta;
	reg  [7:0]  pin_sync;
	reg         aw_held;
	reg         w_held;
	reg  [3:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;

	// ====================
	// helpers
	function addr_ok;
		input [3:0] a;
		begin
			addr_ok = (a == `ASIR_ADDR_STATUS) || (a == `ASIR_ADDR_CONTROL) ||
				(a == `ASIR_ADDR_IRQ_STAT) || (a == `ASIR_ADDR_IRQ_MASK);
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  st;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (st[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	// ====================
	// pin synchronisers
	always @(posedge clk) begin
		if (srst) begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end else begin
			pin_meta <= {switch_pins, gp_input_pins, aux_board_pin}; // see [RULE15]
			pin_sync <= pin_meta;
		end
	end

	// ====================
	// word images
	wire [31:0] status_word;
	wire [31:0] control_word;
	assign status_word = {pin_sync[7:6], pin_sync[5:1], pin_sync[0], 16'h0000, // see [RULE4] [RULE5]
		frame_start_tally, in_vertical_window, acq_state_now, acq_command_next}; // see [RULE1]
	assign control_word = {12'h000, 1'b0, overstep_sticky, 1'b0, gp_output_pins,
		aux_camera_reserved, global_irq_enable, irq_pending_summary,
		frame_end_irq_gate, src_enable};

	// ====================
	// write channel
	wire        do_write;
	wire [31:0] wr_word;
	wire        wr_status;
	wire        wr_control;
	wire        wr_istat;
	wire        wr_imask;
	assign do_write   = aw_held && w_held && !s_axi_bvalid;
	assign wr_status  = do_write && (aw_addr == `ASIR_ADDR_STATUS);
	assign wr_control = do_write && (aw_addr == `ASIR_ADDR_CONTROL);
	assign wr_istat   = do_write && (aw_addr == `ASIR_ADDR_IRQ_STAT);
	assign wr_imask   = do_write && (aw_addr == `ASIR_ADDR_IRQ_MASK);
	assign wr_word = merge(aw_addr == `ASIR_ADDR_STATUS ? status_word :
		aw_addr == `ASIR_ADDR_CONTROL ? control_word : {25'h0, irq_mask}, w_data, w_strb);

	always @(posedge clk) begin
		if (srst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ASIR_RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_ok(aw_addr) ? `ASIR_RESP_OKAY : `ASIR_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
			end
		end
	end

	// ====================
	// read channel
	always @(posedge clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `ASIR_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= addr_ok(s_axi_araddr) ? `ASIR_RESP_OKAY : `ASIR_RESP_SLVERR;
				case ({s_axi_araddr[3:2], 2'b00})
					`ASIR_ADDR_STATUS:   s_axi_rdata <= status_word;
					`ASIR_ADDR_CONTROL:  s_axi_rdata <= control_word;
					`ASIR_ADDR_IRQ_STAT: s_axi_rdata <= {25'h0, irq_status};
					`ASIR_ADDR_IRQ_MASK: s_axi_rdata <= {25'h0, irq_mask};
					default:             s_axi_rdata <= 32'h00000000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ====================
	// acquisition status
	always @(posedge clk) begin
		if (srst) begin
			acq_command_next   <= `ASIR_ACQ_HALT;
			acq_state_now      <= `ASIR_ACQ_HALT;
			in_vertical_window <= 1'b0;
			frame_start_tally  <= 3'h0;
		end else begin
			if (wr_status)
				acq_command_next <= wr_word[`ASIR_ST_CMD_LO +: 2];
			if (frame_start)
				acq_state_now <= acq_command_next; // see [RULE12] [RULE1]
			in_vertical_window <= vwin_active; // see [RULE2]
			if (frame_start)
				frame_start_tally <= frame_start_tally + 3'h1; // see [RULE3]
		end
	end

	// ====================
	// control word and interrupts
	wire       eof_event;
	wire [6:0] events;
	wire [6:0] pend_on;
	wire [6:0] next_irq_status;
	assign eof_event = frame_end && (!frame_end_irq_gate || // see [RULE7]
		acq_state_now == `ASIR_ACQ_SINGLE || acq_state_now == `ASIR_ACQ_CONT); // see [RULE8]
	assign events  = {eof_event, src_events & src_enable}; // see [RULE6]
	assign next_irq_status = (irq_status & ~(wr_istat ? w_data[6:0] & {7{w_strb[0]}} : 7'h00))
		| events;
	assign pend_on = next_irq_status & irq_mask;

	always @(posedge clk) begin
		if (srst) begin
			src_enable          <= 6'h00;
			frame_end_irq_gate  <= 1'b0;
			global_irq_enable   <= 1'b0;
			aux_camera_reserved <= 1'b0;
			gp_output_pins      <= 7'h00;
			overstep_sticky     <= 1'b0;
			irq_status          <= 7'h00;
			irq_mask            <= 7'h00;
			irq_pending_summary <= 1'b0;
			irq                 <= 1'b0;
		end else begin
			if (wr_control) begin
				src_enable          <= wr_word[`ASIR_CT_EN_LO +: 6];
				frame_end_irq_gate  <= wr_word[`ASIR_CT_GATE];
				global_irq_enable   <= wr_word[`ASIR_CT_GLOBAL]; // see [RULE10]
				aux_camera_reserved <= wr_word[`ASIR_CT_AUXCAM];
				gp_output_pins      <= wr_word[`ASIR_CT_GPOUT_LO +: 7]; // see [RULE11]
			end
			if (overstep)
				overstep_sticky <= 1'b1; // see [RULE13]
			else if (wr_control && wr_word[`ASIR_CT_OVS_CLR])
				overstep_sticky <= 1'b0;
			if (wr_imask)
				irq_mask <= wr_word[6:0];
			irq_status          <= next_irq_status;
			irq                 <= global_irq_enable && (|pend_on); // see [RULE14]
			irq_pending_summary <= global_irq_enable && (|pend_on); // see [RULE9]
		end
	end

endmodule

// *** common/asir_defines.vh ***
// Notes on behaviour
// [RULE1] status field shows executing acquisition command: 00 halt,01 abort,10 single,11 continuous.
// [RULE2] in_vertical_window bit is 1 while inside the vertical acquisition window.
// [RULE3] three-bit tally counts frame starts modulo eight.
// [RULE4] aux_board_present reads 1 when the auxiliary board is attached.
// [RULE5] five general inputs and two switch inputs reflected in read-only bits.
// [RULE6] six per-source interrupt enables; 0 suppresses, 1 allows.
// [RULE7] gate clear: frame end interrupt at every end of frame.
// [RULE8] gate set: frame end interrupt only in single or continuous capture.
// [RULE9] summary bit set when an interrupt has been emitted.
// [RULE10] global enable gates every interrupt source together.
// [RULE11] seven general outputs drive the last written values.
// [RULE12] command field written by software takes effect at the next frame.
// [RULE13] overstep sticky latches at first overstep until cleared by clear bit.
// [RULE14] host interrupt only with global enable and an enabled pending source.
// [RULE15] input and switch pins pass two flip-flops before being shown.
`ifndef ASIR_DEFINES_VH
`define ASIR_DEFINES_VH
// ====================
// register byte addresses
`define ASIR_ADDR_STATUS   4'h0
`define ASIR_ADDR_CONTROL  4'h4
`define ASIR_ADDR_IRQ_STAT 4'h8
`define ASIR_ADDR_IRQ_MASK 4'hc
// ====================
// status word fields
`define ASIR_ST_CMD_LO   0
`define ASIR_ST_STATE_LO 2
`define ASIR_ST_WIN      4
`define ASIR_ST_TALLY_LO 5
`define ASIR_ST_AUX      24
`define ASIR_ST_GPIN_LO  25
`define ASIR_ST_SW_LO    30
// ====================
// control word fields
`define ASIR_CT_EN_LO    0
`define ASIR_CT_GATE     6
`define ASIR_CT_SUMMARY  7
`define ASIR_CT_GLOBAL   8
`define ASIR_CT_AUXCAM   9
`define ASIR_CT_GPOUT_LO 10
`define ASIR_CT_OVS      18
`define ASIR_CT_OVS_CLR  19
// ====================
// acquisition codes and interrupt status bits
`define ASIR_ACQ_HALT   2'h0
`define ASIR_ACQ_ABORT  2'h1
`define ASIR_ACQ_SINGLE 2'h2
`define ASIR_ACQ_CONT   2'h3
`define ASIR_IRQ_EOF    6
`define ASIR_RESP_OKAY  2'h0
`define ASIR_RESP_SLVERR 2'h2
`endif

// *** verification/asir_regs_assertions.sv ***
`timescale 1ns/1ps
module asir_regs_assertions (
	// clock and reset
	input logic clk,
	input logic srst,
	// bus handshakes
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	// events and outputs
	input logic frame_start,
	input logic frame_end,
	input logic overstep,
	input logic [5:0] src_events,
	input logic [6:0] gp_output_pins,
	input logic [1:0] acq_state_now,
	input logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ====================
	// cycles since the last write beat or event, saturating
	logic [3:0] wr_age = 4'hf;
	logic [3:0] ev_age = 4'hf;
	always @(posedge clk) begin
		wr_age <= (s_axi_wvalid && s_axi_wready) ? 4'h0 : wr_age + 4'(wr_age != 4'hf);
		ev_age <= (frame_end || overstep || |src_events) ? 4'h0 : ev_age + 4'(ev_age != 4'hf);
	end
	// ====================
	// assertions
	a_state_at_frame: assert property ($changed(acq_state_now) |->
		$past(frame_start) || $past(frame_start, 2) || $past(srst)) else $error("state moved");
	a_gpout_on_write: assert property ($changed(gp_output_pins) |->
		wr_age < 6 || $past(srst)) else $error("gp output moved");
	a_irq_rise_cause: assert property ($rose(irq) |-> wr_age < 6 || ev_age < 4)
		else $error("irq without cause");
	a_irq_fall_cause: assert property ($fell(irq) |-> wr_age < 6 || $past(srst))
		else $error("irq dropped");
	a_reset_quiet: assert property ($past(srst) |-> !irq && gp_output_pins == 7'h0)
		else $error("not idle after reset");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |->
		##[1:2] s_axi_rvalid) else $error("no read data");
	a_one_bresp: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("extra write response");
	a_one_rresp: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("extra read data");
endmodule
bind asir_regs asir_regs_assertions chk_u (.*);

// *** verification/asir_tb_top.sv ***
`timescale 1ns/1ps
`include "asir_defines.vh"
`define CMP(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module asir_regs_tb_top;
	// ====================
	// signals
	logic clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, vwin_active = 0, frame_start = 0, frame_end = 0;
	logic overstep = 0, aux_board_pin = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, irq, e;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, ex, mk, exp_q[$], msk_q[$];
	logic [1:0] s_axi_bresp, s_axi_rresp, switch_pins = 0, acq_state_now;
	logic [5:0] src_events = 0;
	logic [4:0] gp_input_pins = 0;
	logic [6:0] gp_output_pins;
	int n_mismatch = 0, total_checks = 0;
	asir_regs dut_u (.*);
	always #25 clk = ~clk;
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		`CMP("bresp", `ASIR_RESP_OKAY, s_axi_bresp)
		s_axi_bready <= 0;
		@(posedge clk);
	endtask
	// read noting expected value and mask for the monitor
	task automatic rd(input logic [3:0] a, input logic [31:0] v, input logic [31:0] m);
		exp_q.push_back(v & m);
		msk_q.push_back(m);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		@(posedge clk);
	endtask
	// one-cycle pulse: overstep, frame end, frame start, sources
	task automatic ev(input logic [8:0] v);
		{overstep, frame_end, frame_start, src_events} <= v;
		@(posedge clk);
		{overstep, frame_end, frame_start, src_events} <= 9'h0;
		repeat (3) @(posedge clk);
	endtask
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			ex = exp_q.pop_front();
			mk = msk_q.pop_front();
			`CMP("rdata", ex, s_axi_rdata & mk)
			`CMP("rresp", `ASIR_RESP_OKAY, s_axi_rresp)
		end
	end
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#200us;
		n_mismatch++;
		conclude();
	end
	// ====================
	// tests
	initial begin
		void'($urandom(36287));
		repeat (3) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		`CMP("irq", 1'b0, irq)
		d = $urandom;
		wr(`ASIR_ADDR_CONTROL, {15'h0, d[16:10], 4'h0, d[5:0]});
		repeat (2) @(posedge clk);
		`CMP("gpout", d[16:10], gp_output_pins)
		rd(`ASIR_ADDR_CONTROL, d & 32'h1fc3f, 32'h1ff7f);
		repeat (2) begin
			d = $urandom;
			{switch_pins, gp_input_pins, aux_board_pin} <= d[7:0];
			repeat (4) @(posedge clk);
			rd(`ASIR_ADDR_STATUS, {d[7:0], 24'h0}, 32'hff000000);
		end
		for (int c = 0; c < 9; c++) begin
			wr(`ASIR_ADDR_STATUS, c % 4);
			vwin_active <= c[0];
			ev(9'h40);
			`CMP("state", c[1:0], acq_state_now)
			rd(`ASIR_ADDR_STATUS, {3'(c + 1), c[0], c[1:0], c[1:0]}, 32'hff);
		end
		wr(`ASIR_ADDR_IRQ_MASK, 32'h7f);
		for (int g = 0; g < 4; g++) begin
			wr(`ASIR_ADDR_CONTROL, {23'h0, 1'b1, 1'b0, g[0], 6'h3f});
			wr(`ASIR_ADDR_STATUS, {g[1], 1'b0});
			ev(9'h40);
			ev(9'h80);
			e = !g[0] || g[1];
			`CMP("irq", e, irq)
			rd(`ASIR_ADDR_IRQ_STAT, {e, 6'h0}, 32'h40);
			rd(`ASIR_ADDR_CONTROL, {e, 7'h0}, 32'h80);
			wr(`ASIR_ADDR_IRQ_STAT, 32'h7f);
		end
		for (int k = 0; k < 6; k++) begin
			d = $urandom;
			wr(`ASIR_ADDR_IRQ_MASK, d[21:16]);
			wr(`ASIR_ADDR_CONTROL, {23'h0, d[8], 2'h0, d[5:0]});
			ev(9'h1 << k);
			`CMP("irq", d[8] & d[k] & d[16 + k], irq)
			rd(`ASIR_ADDR_IRQ_STAT, d & (32'h1 << k), 32'h3f);
			wr(`ASIR_ADDR_IRQ_STAT, 32'h7f);
			repeat (2) @(posedge clk);
			`CMP("irq", 1'b0, irq)
		end
		ev(9'h100);
		rd(`ASIR_ADDR_CONTROL, 32'h40000, 32'h40000);
		wr(`ASIR_ADDR_CONTROL, 32'h80000);
		rd(`ASIR_ADDR_CONTROL, 32'h0, 32'hc0000);
		conclude();
	end
endmodule
